//--- tb/mem_model.sv
// Memory model: answers read requests after a short or long delay.
// Assumes one request at a time; writes are taken silently.
`timescale 1ns/10ps
`default_nettype none
module mem_model import mem_cmd_pkg::*; (
  input wire logic mclk,
  input wire logic slow,
  input wire mem_req_t mem_req,
  output logic rd_valid,
  output logic [HOLD_W-1:0] rd_data
);
  logic [2:0] cnt = 3'h0;
  logic [HOLD_W-1:0] val;
  initial rd_valid = 1'b0;
  initial rd_data = 16'h0000;
  // Idle data toggles so stale values never look valid
  always @(posedge mclk) begin
    rd_valid <= 1'b0;
    rd_data <= ~rd_data;
    if (mem_req.valid && !mem_req.is_write) begin
      cnt <= slow ? 3'h4 : 3'h1;
      val <= mem_req.addr[15:0] ^ 16'h5A5A;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
      rd_valid <= (cnt == 3'h1);
      if (cnt == 3'h1) rd_data <= val;
    end
  end
endmodule : mem_model
`default_nettype wire

//--- tb/memory_speed_command_unit_tb.sv
// Bench: every command code, a legacy write, fast and slow reads.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module memory_speed_command_unit_tb import mem_cmd_pkg::*;;
  logic mclk = 0, srst = 1, fetch_valid = 0, slow = 0, rd_valid, hold_valid;
  logic clk_en = 1;
  logic force_bus_speed, map_enable, special_map_enable;
  logic [9:0] fetch_opcode = '0;
  logic [WREG_W-1:0] work_reg = '0;
  logic [HOLD_W-1:0] rd_data, hold_data;
  logic [2:0] speed_sel;
  mem_req_t mem_req;
  int err_count = 0, n_checks = 0, cyc = 0;
  always #2.5 mclk = ~mclk;
  memory_speed_command_unit uut (.mclk(mclk), .srst(srst), .clk_en(clk_en),
    .fetch_valid(fetch_valid), .fetch_opcode(fetch_opcode), .work_reg(work_reg),
    .mem_req(mem_req), .rd_valid(rd_valid), .rd_data(rd_data),
    .force_bus_speed(force_bus_speed), .map_enable(map_enable),
    .special_map_enable(special_map_enable), .speed_sel(speed_sel),
    .hold_data(hold_data), .hold_valid(hold_valid));
  mem_model mem (.mclk(mclk), .slow(slow), .mem_req(mem_req), .rd_valid(rd_valid),
    .rd_data(rd_data));
  task conclude;
    if (err_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  // One fetch, then sample the registered answer
  task issue(input logic [9:0] op, input logic [WREG_W-1:0] w);
    @(posedge mclk) {fetch_valid, fetch_opcode, work_reg} <= {1'b1, op, w};
    @(posedge mclk) fetch_valid <= 1'b0;
    #1;
  endtask : issue
  // Cut a hang short
  always @(posedge mclk) if (++cyc == 500) begin
    err_count++;
    conclude();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      issue(OPC_CMD_WRITE, {36'h0_0000_0127, 4'(i), 16'h1234});
      `CHK("fast", 1'b1, force_bus_speed)
      `CHK("req", {i < 6, i < 6 && !i[0]}, {mem_req.valid, mem_req.is_write})
      if (i < 6 && !i[0]) `CHK("data", 16'h1234, mem_req.data)
      if (i == 2) `CHK("log", 24'h27_0012, {mem_req.page, mem_req.bank, mem_req.addr[15:0]})
      if (i == 4) `CHK("phy", 24'h00_0012, mem_req.addr)
      if (i == 6 || i == 7) `CHK("map", i[0], map_enable)
      if (i > 13) `CHK("smap", i[0], special_map_enable)
      if (i > 7 && i < 14) `CHK("speed", 3'(i - 8), speed_sel)
    end
    `CHK("hold", 16'h5A48, hold_data)
    `CHK("hvld", 1'b1, hold_valid)
    issue(OPC_PROG_WRITE, 56'h00_0000_0123_4F78);
    `CHK("prog", {2'h3, REQ_PROG, 32'h1234_0F78}, {force_bus_speed, mem_req.is_write,
      mem_req.kind, mem_req.addr[15:0], mem_req.data})
    slow <= 1'b1;
    issue(OPC_CMD_WRITE, 56'h00_0000_AB05_0000);
    repeat (3) @(posedge mclk);
    #1;
    `CHK("wait", 16'h5A48, hold_data)
    repeat (4) @(posedge mclk);
    #1;
    `CHK("slow", 16'h5AF1, hold_data)
    // Frozen by clk_en: a speed command must change nothing
    @(posedge mclk) clk_en <= 1'b0;
    issue(OPC_CMD_WRITE, 56'h00_0000_0008_0000);
    `CHK("frz", 5'h05, {force_bus_speed, mem_req.valid, speed_sel})
    @(posedge mclk) clk_en <= 1'b1;
    issue(OPC_CMD_WRITE, 56'h00_0000_0008_0000);
    `CHK("run", 5'h10, {force_bus_speed, mem_req.valid, speed_sel})
    conclude();
  end
endmodule : memory_speed_command_unit_tb
`default_nettype wire

//--- tb/mscu_asserts.sv
// Checker for the command unit; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module mscu_asserts import mem_cmd_pkg::*; (
  input wire logic mclk, srst, clk_en, fetch_valid, rd_valid, force_bus_speed, map_enable,
  input wire logic [9:0] fetch_opcode,
  input wire logic [WREG_W-1:0] work_reg,
  input wire logic [HOLD_W-1:0] rd_data, hold_data,
  input wire mem_req_t mem_req,
  input wire logic [2:0] speed_sel
);
  wire cmd = clk_en && fetch_valid && fetch_opcode == OPC_CMD_WRITE;
  wire prog = clk_en && fetch_valid && fetch_opcode == OPC_PROG_WRITE;
  wire [3:0] cd = work_reg[19:16];
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_bus_speed: assert property ((cmd || prog) |=> force_bus_speed) else $error("speed");
  a_write_auto: assert property (cmd && cd < 4'h6 && !cd[0] |=>
    mem_req.valid && mem_req.is_write && mem_req.data == $past(work_reg[15:0])) else $error("wr");
  a_read_req: assert property (cmd && cd < 4'h6 && cd[0] |=> mem_req.valid && !mem_req.is_write)
    else $error("rd");
  a_map_level: assert property (cmd && cd inside {4'h6, 4'h7} |=> map_enable == $past(cd[0]))
    else $error("map");
  a_speed_code: assert property (cmd && cd inside {[4'h8:4'hD]} |=>
    speed_sel == 3'($past(cd) - 4'h8)) else $error("sel");
  a_prog_pad: assert property (prog |=> mem_req.kind == REQ_PROG &&
    mem_req.data == {PW_PAD, $past(work_reg[11:0])} && mem_req.addr[15:0] == $past(work_reg[27:12]))
    else $error("prog");
  a_hold_load: assert property (rd_valid && clk_en |=> hold_data == $past(rd_data)) else $error("ld");
  a_hold_keep: assert property (!rd_valid |=> $stable(hold_data)) else $error("keep");
endmodule : mscu_asserts
bind memory_speed_command_unit mscu_asserts chk (.*);
`default_nettype wire

//--- verilog/mem_cmd_pkg.sv
// Package for the memory and speed command unit: opcodes, digit fields, codes.
// Assumes a core that presents each fetched 10-bit opcode with a strobe.
package mem_cmd_pkg;
  localparam int WREG_W = 56;
  localparam logic [9:0] OPC_CMD_WRITE = 10'h1_FC;
  localparam logic [9:0] OPC_PROG_WRITE = 10'h040;
  // Digit positions
  localparam int DIGIT_W = 4;
  localparam int LADDR_W = 16;
  localparam int PW_PAGE_LSB = 24;
  localparam int SPEED_W = 3;
  localparam int CMD_LSB = 16;
  localparam int BANK_LSB = 20;
  localparam int PAGE_LSB = 24;
  localparam int MAPDATA_LSB = 0;
  localparam int LADDR_LSB = 24;
  localparam int PADDR_LSB = 24;
  localparam int WDATA_LSB = 0;
  localparam int PW_ADDR_LSB = 12;
  localparam int PW_DATA_LSB = 0;
  localparam int PW_DATA_W = 12;
  localparam int PADDR_W = 24;
  localparam int MEM_W = 16;
  localparam int HOLD_W = 16;
  localparam logic [3:0] PW_PAD = 4'h0;
  // Command codes
  localparam logic [3:0] C_WR_MAP = 4'h0;
  localparam logic [3:0] C_RD_MAP = 4'h1;
  localparam logic [3:0] C_WR_LOG = 4'h2;
  localparam logic [3:0] C_RD_LOG = 4'h3;
  localparam logic [3:0] C_WR_PHY = 4'h4;
  localparam logic [3:0] C_RD_PHY = 4'h5;
  localparam logic [3:0] C_MAP_OFF = 4'h6;
  localparam logic [3:0] C_MAP_ON = 4'h7;
  localparam logic [3:0] C_SPD_1X = 4'h8;
  localparam logic [3:0] C_SPD_50X = 4'hD;
  localparam logic [3:0] C_SMAP_OFF = 4'hE;
  localparam logic [3:0] C_SMAP_ON = 4'hF;
  // Speed selection: 0 normal, 1..5 = 2x,5x,10x,20x,50x
  localparam logic [2:0] SPEED_NORMAL = 3'h0;
  typedef enum logic [1:0] {REQ_MAP, REQ_LOG, REQ_PHY, REQ_PROG} req_kind_t;
  typedef struct packed {
    logic valid;
    logic is_write;
    req_kind_t kind;
    logic [3:0] page;
    logic [3:0] bank;
    logic [PADDR_W-1:0] addr;
    logic [MEM_W-1:0] data;
  } mem_req_t;
endpackage : mem_cmd_pkg

//--- verilog/memory_speed_command_unit.sv
// ****************************************************************************
// Memory and speed command unit
// ****************************************************************************
// Decodes the command-write and legacy program-write opcodes, which the core
// executes as one-cycle no-ops, into memory requests, mapping enables and
// an execution speed selection.
// Assumes a core that shows each fetched opcode with fetch_valid and the
// working register in the same cycle, and a memory system that answers
// each read request with a single rd_valid pulse carrying rd_data.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Command-write opcode is a one-cycle no-op here decoded and acted upon.
// - Command-write fetches always run at normal bus speed.
// - Write commands send working-register data to destination automatically.
// - Read commands latch result in a holding register read via I/O port.
// - Command code comes from digit 4; operands from other digits.
// - Codes 0,2,4 write; 6/7 global map off/on; E/F special map off/on.
// - Code 8 normal speed; 9..D select 2,5,10,20,50 times.
// - Codes 1,3,5 read map entry, logical, physical; result latched.
// - Legacy program write is one-cycle no-op, always at bus speed.
// - Legacy write address from digits 6-3, data from digits 2-0.
// - Legacy write goes to the bank active in the address page.
// - Legacy write stores twelve data bits, upper four forced zero.
module memory_speed_command_unit import mem_cmd_pkg::*; (
  // Clock and control
  input wire logic mclk,
  input wire logic srst,
  input wire logic clk_en,
  // Core fetch side
  input wire logic fetch_valid,
  input wire logic [9:0] fetch_opcode,
  input wire logic [WREG_W-1:0] work_reg,
  // Memory side
  output var mem_req_t mem_req,
  input wire logic rd_valid,
  input wire logic [HOLD_W-1:0] rd_data,
  // Status
  output logic force_bus_speed,
  output logic map_enable,
  output logic special_map_enable,
  output logic [2:0] speed_sel,
  output logic [HOLD_W-1:0] hold_data,
  output logic hold_valid
);

  // **************************************************************************
  // Opcode decode
  // **************************************************************************

  // Opcode strobes; clk_en is applied where state is updated
  logic is_cmd;
  logic is_prog;
  assign is_cmd = fetch_valid && (fetch_opcode == OPC_CMD_WRITE);
  assign is_prog = fetch_valid && (fetch_opcode == OPC_PROG_WRITE);

  // Command code sits in digit 4 of the working register
  logic [DIGIT_W-1:0] code;
  assign code = work_reg[CMD_LSB +: DIGIT_W];

  // Code classes: memory access, read direction, speed selection
  logic code_is_mem;
  logic code_is_read;
  logic code_is_speed;
  assign code_is_mem = (code <= C_RD_PHY);
  assign code_is_read = (code == C_RD_MAP) || (code == C_RD_LOG) || (code == C_RD_PHY);
  assign code_is_speed = (code >= C_SPD_1X) && (code <= C_SPD_50X);

  // **************************************************************************
  // Operand fields
  // **************************************************************************

  // Command operands: page, bank, addresses and write data
  logic [DIGIT_W-1:0] cmd_page;
  logic [DIGIT_W-1:0] cmd_bank;
  logic [LADDR_W-1:0] cmd_log_addr;
  logic [PADDR_W-1:0] cmd_phy_addr;
  logic [MEM_W-1:0] cmd_wdata;
  assign cmd_page = work_reg[PAGE_LSB +: DIGIT_W];
  assign cmd_bank = work_reg[BANK_LSB +: DIGIT_W];
  assign cmd_log_addr = work_reg[LADDR_LSB +: LADDR_W];
  assign cmd_phy_addr = work_reg[PADDR_LSB +: PADDR_W];
  assign cmd_wdata = work_reg[WDATA_LSB +: MEM_W];

  // Legacy operands: address in digits 6-3, data in digits 2-0
  logic [DIGIT_W-1:0] prog_page;
  logic [LADDR_W-1:0] prog_addr;
  logic [PW_DATA_W-1:0] prog_data;
  assign prog_page = work_reg[PW_PAGE_LSB +: DIGIT_W];
  assign prog_addr = work_reg[PW_ADDR_LSB +: LADDR_W];
  assign prog_data = work_reg[PW_DATA_LSB +: PW_DATA_W];

  // **************************************************************************
  // Bus speed override
  // **************************************************************************

  // Both special opcodes run at bus speed whatever speed_sel holds;
  // the flag stands for the one cycle after the fetch
  always_ff @(posedge mclk) begin
    if (srst) begin
      force_bus_speed <= 1'b0;
    end else if (clk_en) begin
      force_bus_speed <= is_cmd || is_prog;
    end
  end

  // **************************************************************************
  // Mapping enables
  // **************************************************************************

  // Global mapping enable; it comes up off after reset
  always_ff @(posedge mclk) begin
    if (srst) begin
      map_enable <= 1'b0;
    end else if (clk_en && is_cmd) begin
      if (code == C_MAP_OFF) begin
        map_enable <= 1'b0;
      end else if (code == C_MAP_ON) begin
        map_enable <= 1'b1;
      end
    end
  end

  // Special mapping enable; it also comes up off after reset
  always_ff @(posedge mclk) begin
    if (srst) begin
      special_map_enable <= 1'b0;
    end else if (clk_en && is_cmd) begin
      if (code == C_SMAP_OFF) begin
        special_map_enable <= 1'b0;
      end else if (code == C_SMAP_ON) begin
        special_map_enable <= 1'b1;
      end
    end
  end

  // **************************************************************************
  // Execution speed
  // **************************************************************************

  // Codes 8 to D map onto selections 0 to 5; other codes leave it alone
  always_ff @(posedge mclk) begin
    if (srst) begin
      speed_sel <= SPEED_NORMAL;
    end else if (clk_en && is_cmd && code_is_speed) begin
      speed_sel <= SPEED_W'(code - C_SPD_1X);
    end
  end

  // **************************************************************************
  // Memory request
  // **************************************************************************

  // Request built from the decoded fields; an all-zero request is idle.
  // Codes 6 to F never reach the memory, so they cannot disturb it.
  mem_req_t next_req;
  always_comb begin
    next_req = '0;
    if (is_prog) begin
      next_req.valid = 1'b1;
      next_req.is_write = 1'b1;
      next_req.kind = REQ_PROG;
      next_req.page = prog_page;
      next_req.addr = PADDR_W'(prog_addr);
      next_req.data = {PW_PAD, prog_data};
    end else if (is_cmd && code_is_mem) begin
      next_req.valid = 1'b1;
      next_req.is_write = !code_is_read;
      next_req.page = cmd_page;
      next_req.bank = cmd_bank;
      next_req.data = cmd_wdata;
      unique case (code)
        C_WR_MAP, C_RD_MAP: begin
          next_req.kind = REQ_MAP;
        end
        C_WR_LOG, C_RD_LOG: begin
          next_req.kind = REQ_LOG;
          next_req.addr = PADDR_W'(cmd_log_addr);
        end
        C_WR_PHY, C_RD_PHY: begin
          next_req.kind = REQ_PHY;
          next_req.addr = cmd_phy_addr;
        end
        default: begin
          next_req.kind = REQ_MAP;
        end
      endcase
    end
  end

  // Registered request, one cycle per accepted opcode
  always_ff @(posedge mclk) begin
    if (srst) begin
      mem_req <= '0;
    end else if (clk_en) begin
      mem_req <= next_req;
    end
  end

  // **************************************************************************
  // Read-result holding register
  // **************************************************************************

  // Only read answers load it; write commands leave it untouched
  always_ff @(posedge mclk) begin
    if (srst) begin
      hold_data <= '0;
    end else if (clk_en && rd_valid) begin
      hold_data <= rd_data;
    end
  end

  // Marks that the holding register has been loaded at least once
  always_ff @(posedge mclk) begin
    if (srst) begin
      hold_valid <= 1'b0;
    end else if (clk_en && rd_valid) begin
      hold_valid <= 1'b1;
    end
  end

endmodule : memory_speed_command_unit
`default_nettype wire
